// [hw/ckfo_device.sv]
// module: serial-controlled 1-to-18 clock fan-out with per-output enables
`timescale 1ns/1ps
module ckfo_device
   import ckfo_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // serial control link
   ckfo_link_if.device               link,
   // reference clock and tristate control
   input  wire logic                 refClk,
   input  wire logic                 outEnable,
   // fan-out outputs with per-pin enables
   output logic [ckfo_pkg::LANE_W-1:0] lane0_clk_out,
   output logic [ckfo_pkg::LANE_W-1:0] lane1_clk_out,
   output logic [ckfo_pkg::LANE_W-1:0] lane2_clk_out,
   output logic [ckfo_pkg::LANE_W-1:0] lane3_clk_out,
   output logic [1:0]                  pll_feedback_out,
   output logic [ckfo_pkg::NUM_OUT-1:0] clkOutOe,
   // count of bytes written since the last start, for observation
   output logic [1:0]                  byteIndex
);
   import ckfo_pkg::*;

   typedef struct packed {
      logic [1:0]          sclSync;
      logic [1:0]          sdaSync;
      logic                sclLast;
      logic                sdaLast;
      ckfo_state_e         state;
      logic [3:0]          bitCnt;
      logic [7:0]          shift;
      logic [1:0]          regIdx;
      logic [NUM_REG-1:0][7:0] regs;
      logic [NUM_OUT-1:0]  enStage;
      logic [NUM_OUT-1:0]  enLive;
      logic [1:0]          refSync;
      logic                ackDrive;
   } ckfo_dev_s;

   ckfo_dev_s st_reg;
   ckfo_dev_s st_next;

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic [NUM_OUT-1:0] enMap;
   logic [NUM_OUT-1:0] gatedClk;

   // register bytes to output order: lane0..lane3 then feedback
   function automatic logic [NUM_OUT-1:0] map_enables(logic [NUM_REG-1:0][7:0] r);
      logic [NUM_OUT-1:0] m;
      m = '0;
      m[3:0]   = r[REG_LANE_LOW][LO_NIB_LSB +: LANE_W];
      m[7:4]   = r[REG_LANE_LOW][HI_NIB_LSB +: LANE_W];
      m[11:8]  = r[REG_LANE_HIGH][LO_NIB_LSB +: LANE_W];
      m[15:12] = r[REG_LANE_HIGH][HI_NIB_LSB +: LANE_W];
      m[16]    = r[REG_FEEDBACK][FB0_BIT];
      m[17]    = r[REG_FEEDBACK][FB1_BIT];
      return m;
   endfunction : map_enables

   assign sclRise   = st_reg.sclSync[1] & ~st_reg.sclLast;
   assign sclFall   = ~st_reg.sclSync[1] & st_reg.sclLast;
   assign startCond = st_reg.sclSync[1] & st_reg.sclLast & st_reg.sdaLast & ~st_reg.sdaSync[1];
   assign stopCond  = st_reg.sclSync[1] & st_reg.sclLast & ~st_reg.sdaLast & st_reg.sdaSync[1];
   assign enMap     = map_enables(st_reg.regs);

   always_comb begin
      st_next = st_reg;
      st_next.sclSync = {st_reg.sclSync[0], link.serialClk};
      st_next.sdaSync = {st_reg.sdaSync[0], link.serialData};
      st_next.refSync = {st_reg.refSync[0], refClk};
      st_next.sclLast = st_reg.sclSync[1];
      st_next.sdaLast = st_reg.sdaSync[1];
      st_next.enStage = enMap;
      if (startCond) begin
         st_next.state    = CKFO_S_ADDR;
         st_next.bitCnt   = '0;
         st_next.regIdx   = '0;
         st_next.ackDrive = 1'b0;
      end else if (stopCond) begin
         st_next.state    = CKFO_S_IDLE;
         st_next.ackDrive = 1'b0;
      end else begin
         case (st_reg.state)
            CKFO_S_ADDR, CKFO_S_DATA, CKFO_S_IGN: begin
               if (sclRise) begin
                  st_next.shift  = {st_reg.shift[6:0], st_reg.sdaSync[1]};
                  st_next.bitCnt = st_reg.bitCnt + 4'h1;
               end
               if (sclFall && st_reg.bitCnt == 4'h8) begin
                  st_next.bitCnt = '0;
                  if (st_reg.state == CKFO_S_ADDR) begin
                     // write only: read address is not acknowledged
                     if (st_reg.shift[7:1] == SLAVE_ADDR && !st_reg.shift[0]) begin
                        st_next.state    = CKFO_S_ACK;
                        st_next.ackDrive = 1'b1;
                     end else begin
                        st_next.state = CKFO_S_NACK;
                     end
                  end else if (st_reg.state == CKFO_S_DATA) begin
                     if (st_reg.regIdx < 2'(NUM_REG)) begin
                        st_next.regs[st_reg.regIdx] = st_reg.shift;
                        st_next.regIdx   = st_reg.regIdx + 2'h1;
                        st_next.state    = CKFO_S_ACK;
                        st_next.ackDrive = 1'b1;
                     end else begin
                        st_next.state = CKFO_S_NACK;
                     end
                  end
               end
            end
            CKFO_S_ACK: begin
               if (sclFall) begin
                  st_next.ackDrive = 1'b0;
                  st_next.state    = CKFO_S_DATA;
               end
            end
            CKFO_S_NACK: begin
               if (sclFall) begin
                  st_next.state = CKFO_S_IGN;
               end
            end
            default: begin
               st_next.state = CKFO_S_IDLE;
            end
         endcase
         if (st_reg.state == CKFO_S_IGN && sclFall && st_reg.bitCnt == 4'h8) begin
            st_next.state = CKFO_S_NACK;
         end
      end
      // enables change only while the two-stage synchronized reference copy refSync[1] is low
      if (!st_reg.refSync[1]) begin
         st_next.enLive = st_reg.enStage;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg          <= '0;
         st_reg.sclSync  <= 2'h3;
         st_reg.sdaSync  <= 2'h3;
         st_reg.sclLast  <= 1'b1;
         st_reg.sdaLast  <= 1'b1;
         st_reg.state    <= CKFO_S_IDLE;
         st_reg.regs     <= {NUM_REG{ENABLE_RESET}};
         st_reg.enStage  <= '1;
         st_reg.enLive   <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   // fan-out path is combinational from the reference input
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_out
         assign gatedClk[g] = refClk & st_reg.enLive[g];
      end
   endgenerate

   assign lane0_clk_out    = gatedClk[3:0];
   assign lane1_clk_out    = gatedClk[7:4];
   assign lane2_clk_out    = gatedClk[11:8];
   assign lane3_clk_out    = gatedClk[15:12];
   assign pll_feedback_out = gatedClk[17:16];
   assign clkOutOe         = {NUM_OUT{outEnable}};
   assign byteIndex        = st_reg.regIdx;

   assign link.serialDataDevOut = 1'b0;
   assign link.serialDataDevOe  = st_reg.ackDrive;
endmodule : ckfo_device

// [hw/ckfo_link_if.sv]
// interface: the two-wire control link between master and fan-out device
`timescale 1ns/1ps
interface ckfo_link_if;
   logic serialClkOut;
   logic serialClkOe;
   logic serialDataMstOut;
   logic serialDataMstOe;
   logic serialDataDevOut;
   logic serialDataDevOe;
   logic serialClk;
   logic serialData;

   // open-drain resolution with pull-ups
   assign serialClk  = ~(serialClkOe & ~serialClkOut);
   assign serialData = ~((serialDataMstOe & ~serialDataMstOut) |
                         (serialDataDevOe & ~serialDataDevOut));

   modport device (
      input  serialClk,
      input  serialData,
      output serialDataDevOut,
      output serialDataDevOe
   );
   modport master (
      input  serialClk,
      input  serialData,
      output serialClkOut,
      output serialClkOe,
      output serialDataMstOut,
      output serialDataMstOe
   );
endinterface : ckfo_link_if

// [hw/ckfo_master.sv]
// module: serial master that writes the three enable bytes in order
`timescale 1ns/1ps
module ckfo_master
   import ckfo_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // serial control link
   ckfo_link_if.master            link,
   // user command: write all three bytes
   input  wire logic              wrReq,
   input  wire logic [7:0]        wrByte0,
   input  wire logic [7:0]        wrByte1,
   input  wire logic [7:0]        wrByte2,
   // status
   output logic                   busy,
   output logic                   done,
   output logic                   ackErr
);
   import ckfo_pkg::*;

   localparam int QW = (SCL_QTR_CYC < 1) ? 1 : SCL_QTR_CYC;

   typedef struct packed {
      ckfo_mstate_e  state;
      logic [15:0]   div;
      logic [1:0]    phase;
      logic [1:0]    byteNum;
      logic [3:0]    bitCnt;
      logic [7:0]    shift;
      logic [23:0]   data;
      logic          scl;
      logic          sda;
      logic          sdaInS0;
      logic          sdaIn;
      logic          done;
      logic          ackErr;
   } ckfo_mst_s;

   ckfo_mst_s st_reg;
   ckfo_mst_s st_next;
   logic      tick;

   assign tick = (st_reg.div == 16'(QW - 1));

   always_comb begin
      st_next         = st_reg;
      st_next.done    = 1'b0;
      st_next.sdaInS0 = link.serialData;
      st_next.sdaIn   = st_reg.sdaInS0;
      st_next.div     = tick ? 16'h0 : st_reg.div + 16'h1;
      if (tick && st_reg.state != CKFO_M_IDLE) begin
         st_next.phase = st_reg.phase + 2'h1;
      end
      case (st_reg.state)
         CKFO_M_IDLE: begin
            st_next.div = 16'h0;
            if (wrReq) begin
               st_next.state   = CKFO_M_START;
               st_next.data    = {wrByte0, wrByte1, wrByte2};
               st_next.shift   = {SLAVE_ADDR, 1'b0};
               st_next.byteNum = 2'h0;
               st_next.bitCnt  = 4'h0;
               st_next.phase   = 2'h0;
               st_next.ackErr  = 1'b0;
            end
         end
         CKFO_M_START: begin
            if (tick) begin
               if (st_reg.phase == 2'h0) st_next.sda = 1'b0;
               if (st_reg.phase == 2'h1) begin
                  st_next.scl   = 1'b0;
                  st_next.state = CKFO_M_BIT;
                  st_next.phase = 2'h0;
               end
            end
         end
         CKFO_M_BIT, CKFO_M_ACK: begin
            if (tick) begin
               case (st_reg.phase)
                  2'h0: st_next.sda = (st_reg.state == CKFO_M_ACK) ? 1'b1 : st_reg.shift[7];
                  2'h1: st_next.scl = 1'b1;
                  2'h2: begin
                     if (st_reg.state == CKFO_M_ACK && st_reg.sdaIn) st_next.ackErr = 1'b1;
                  end
                  default: begin
                     st_next.scl = 1'b0;
                     if (st_reg.state == CKFO_M_BIT) begin
                        st_next.shift  = {st_reg.shift[6:0], 1'b0};
                        st_next.bitCnt = st_reg.bitCnt + 4'h1;
                        if (st_reg.bitCnt == 4'h7) begin
                           // let go of data with the eighth falling clock, before the ack
                           st_next.sda   = 1'b1;
                           st_next.state = CKFO_M_ACK;
                        end
                     end else begin
                        st_next.bitCnt = 4'h0;
                        if (st_reg.byteNum == 2'(NUM_REG) || st_reg.ackErr) begin
                           st_next.state = CKFO_M_STOP;
                        end else begin
                           st_next.shift   = st_reg.data[23:16];
                           st_next.data    = {st_reg.data[15:0], 8'h00};
                           st_next.byteNum = st_reg.byteNum + 2'h1;
                           st_next.state   = CKFO_M_BIT;
                        end
                     end
                  end
               endcase
            end
         end
         CKFO_M_STOP: begin
            if (tick) begin
               case (st_reg.phase)
                  2'h0: st_next.sda = 1'b0;
                  2'h1: st_next.scl = 1'b1;
                  2'h2: st_next.sda = 1'b1;
                  default: st_next.state = CKFO_M_DONE;
               endcase
            end
         end
         default: begin
            st_next.done  = 1'b1;
            st_next.state = CKFO_M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg       <= '0;
         st_reg.state <= CKFO_M_IDLE;
         st_reg.scl   <= 1'b1;
         st_reg.sda   <= 1'b1;
         st_reg.sdaInS0 <= 1'b1;
         st_reg.sdaIn <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.serialClkOut    = 1'b0;
   assign link.serialClkOe     = ~st_reg.scl;
   assign link.serialDataMstOut = 1'b0;
   assign link.serialDataMstOe  = ~st_reg.sda;
   assign busy   = (st_reg.state != CKFO_M_IDLE);
   assign done   = st_reg.done;
   assign ackErr = st_reg.ackErr;
endmodule : ckfo_master

// [hw/ckfo_pkg.sv]
// package: constants and types for the clock fan-out enable controller
package ckfo_pkg;
   localparam int            NUM_OUT       = 18;
   localparam int            LANE_W        = 4;
   localparam int            NUM_REG       = 3;
   localparam logic [6:0]    SLAVE_ADDR    = 7'h69;
   localparam logic [7:0]    ENABLE_RESET  = 8'hFF;
   localparam int            REG_LANE_LOW  = 0;
   localparam int            REG_LANE_HIGH = 1;
   localparam int            REG_FEEDBACK  = 2;
   localparam int            FB0_BIT       = 6;
   localparam int            FB1_BIT       = 7;
   localparam int            LO_NIB_LSB    = 0;
   localparam int            HI_NIB_LSB    = 4;
   // master timing: serial clock period in ns and system clock period in ns
   localparam int            SCL_PERIOD_NS = 10000;
   localparam int            CLK_PERIOD_NS = 4;
   localparam int            SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      CKFO_S_IDLE  = 3'b000,
      CKFO_S_ADDR  = 3'b001,
      CKFO_S_ACK   = 3'b010,
      CKFO_S_DATA  = 3'b011,
      CKFO_S_NACK  = 3'b100,
      CKFO_S_IGN   = 3'b101
   } ckfo_state_e;

   typedef enum logic [2:0] {
      CKFO_M_IDLE  = 3'b000,
      CKFO_M_START = 3'b001,
      CKFO_M_BIT   = 3'b010,
      CKFO_M_ACK   = 3'b011,
      CKFO_M_STOP  = 3'b100,
      CKFO_M_DONE  = 3'b101
   } ckfo_mstate_e;
endpackage : ckfo_pkg

// [tb/ckfo_link_props.sv]
// checker: timing and framing of the two-wire control link
`timescale 1ns/1ps
module ckfo_link_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link wires and drivers
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic serialClkOut,
   input wire logic serialClkOe,
   input wire logic serialDataMstOut,
   input wire logic serialDataMstOe,
   input wire logic serialDataDevOut,
   input wire logic serialDataDevOe
);
   logic        sclD;
   logic        sdaD;
   logic [5:0]  riseCnt;
   logic [15:0] hiCnt;
   logic [15:0] loCnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // serial clock rises since the last start, and high and low run lengths
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclD    <= 1'b1;
         sdaD    <= 1'b1;
         riseCnt <= 6'h00;
         hiCnt   <= 16'h0000;
         loCnt   <= 16'h0000;
      end else begin
         sclD  <= serialClk;
         sdaD  <= serialData;
         hiCnt <= serialClk ? (&hiCnt ? hiCnt : hiCnt + 16'h0001) : 16'h0000;
         loCnt <= !serialClk ? (&loCnt ? loCnt : loCnt + 16'h0001) : 16'h0000;
         if (sclD && serialClk && sdaD && !serialData) begin
            riseCnt <= 6'h00;
         end else if (!sclD && serialClk) begin
            riseCnt <= riseCnt + 6'h01;
         end
      end
   end

   sequence startSeq;
      $past(serialClk) && serialClk && $fell(serialData);
   endsequence
   sequence stopSeq;
      $past(serialClk) && serialClk && $rose(serialData);
   endsequence

   a_pull_low_only: assert property (!serialClkOut && !serialDataMstOut && !serialDataDevOut)
      else $error("link driver drives a high level");
   a_ack_edges_low: assert property ($changed(serialDataDevOe) |-> !serialClk)
      else $error("ack drive changed while serial clock high");
   a_ack_stable_high: assert property (serialClk && $past(serialClk) |-> $stable(serialDataDevOe))
      else $error("ack drive moved during clock high");
   a_ack_after_eight: assert property ($rose(serialDataDevOe) |-> riseCnt % 6'd9 == 6'd8)
      else $error("ack started at wrong bit position");
   a_ack_one_bit: assert property ($fell(serialDataDevOe) |-> riseCnt % 6'd9 == 6'd0)
      else $error("ack did not last one bit");
   a_master_yields_ack: assert property (serialDataDevOe |-> !serialDataMstOe)
      else $error("master drove data during ack");
   a_scl_high_time: assert property ($fell(serialClk) && riseCnt != 6'h00 |-> hiCnt >= 16'd1000)
      else $error("serial clock high too short");
   a_scl_low_time: assert property ($rose(serialClk) |-> loCnt >= 16'd1175)
      else $error("serial clock low too short");
   a_stop_after_three: assert property (stopSeq |-> riseCnt == 6'd37)
      else $error("stop not after address and three bytes");
   a_start_no_ack: assert property (startSeq |-> !serialDataDevOe && serialClkOe == 1'b0)
      else $error("start while a driver held the link");
endmodule : ckfo_link_props

// [tb/tb_top.sv]
// testbench: master and fan-out device joined over the control link
`timescale 1ns/1ps
module tb_top;
   import ckfo_pkg::*;
   logic                clk;
   logic                rst_n;
   logic                refClk;
   logic                refRun;
   logic                outEnable;
   logic                wrReq;
   logic [7:0]          wrByte0;
   logic [7:0]          wrByte1;
   logic [7:0]          wrByte2;
   logic                busy;
   logic                done;
   logic                ackErr;
   logic [LANE_W-1:0]   lane0;
   logic [LANE_W-1:0]   lane1;
   logic [LANE_W-1:0]   lane2;
   logic [LANE_W-1:0]   lane3;
   logic [1:0]          fb;
   logic [NUM_OUT-1:0]  clkOutOe;
   logic [1:0]          byteIdx;
   int                  mismatches;
   int                  checks_done;
   int                  seedVal;

   ckfo_link_if ckfo_link_if_i ();
   ckfo_device ckfo_device_i (.clk(clk), .rst_n(rst_n), .link(ckfo_link_if_i),
      .refClk(refClk), .outEnable(outEnable), .lane0_clk_out(lane0),
      .lane1_clk_out(lane1), .lane2_clk_out(lane2), .lane3_clk_out(lane3),
      .pll_feedback_out(fb), .clkOutOe(clkOutOe), .byteIndex(byteIdx));
   ckfo_master ckfo_master_i (.clk(clk), .rst_n(rst_n), .link(ckfo_link_if_i),
      .wrReq(wrReq), .wrByte0(wrByte0), .wrByte1(wrByte1), .wrByte2(wrByte2),
      .busy(busy), .done(done), .ackErr(ackErr));
   ckfo_link_props ckfo_link_props_i (.clk(clk), .rst_n(rst_n),
      .serialClk(ckfo_link_if_i.serialClk), .serialData(ckfo_link_if_i.serialData),
      .serialClkOut(ckfo_link_if_i.serialClkOut), .serialClkOe(ckfo_link_if_i.serialClkOe),
      .serialDataMstOut(ckfo_link_if_i.serialDataMstOut),
      .serialDataMstOe(ckfo_link_if_i.serialDataMstOe),
      .serialDataDevOut(ckfo_link_if_i.serialDataDevOut),
      .serialDataDevOe(ckfo_link_if_i.serialDataDevOe));

   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (refRun) begin
         refClk <= ~refClk;
      end
   end

   // expected fan-out vector, feedback pair at the top, lane zero at the bottom
   function automatic logic [17:0] expOut(input logic [7:0] b0, input logic [7:0] b1,
                                          input logic [7:0] b2, input logic r);
      return {b2[7:6], b1, b0} & {18{r}};
   endfunction : expOut

   task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // outputs against enables over several reference clock phases
   task automatic checkOuts(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      repeat (6) begin
         @(negedge clk);
         check("fan-out", expOut(b0, b1, b2, refClk), {fb, lane3, lane2, lane1, lane0});
         check("drive enable", {18{outEnable}}, clkOutOe);
      end
   endtask : checkOuts

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
      int         i;
      clk = 1'b0;
      rst_n = 1'b0;
      refClk = 1'b0;
      refRun = 1'b1;
      outEnable = 1'b1;
      wrReq = 1'b0;
      wrByte0 = 8'h00;
      wrByte1 = 8'h00;
      wrByte2 = 8'h00;
      mismatches = 0;
      checks_done = 0;
      seedVal = $urandom(32'h95F8);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      checkOuts(ENABLE_RESET, ENABLE_RESET, ENABLE_RESET);
      $display("test reset defaults done");
      @(posedge clk);
      outEnable <= 1'b0;
      checkOuts(ENABLE_RESET, ENABLE_RESET, ENABLE_RESET);
      @(posedge clk);
      outEnable <= 1'b1;
      $display("test tristate done");
      // random lane zero/one byte, all-off lane two/three corner, feedback one only
      b0 = 8'($urandom());
      b1 = 8'h00;
      b2 = {2'b10, 6'($urandom())};
      @(posedge clk);
      wrByte0 <= b0;
      wrByte1 <= b1;
      wrByte2 <= b2;
      wrReq <= 1'b1;
      @(posedge clk);
      wrReq <= 1'b0;
      for (i = 0; i < 99000 && done !== 1'b1; i++) begin
         @(negedge clk);
      end
      if (done !== 1'b1) begin
         mismatches++;
         $display("[FAIL] transfer done expected 1 seen %b", done);
      end
      check("ack error", 18'h0, {17'h0, ackErr});
      check("byte count", 18'(NUM_REG), {16'h0, byteIdx});
      check("busy", 18'h0, {17'h0, busy});
      repeat (20) @(negedge clk);
      checkOuts(b0, b1, b2);
      $display("test enable write done");
      @(posedge clk);
      outEnable <= 1'b0;
      checkOuts(b0, b1, b2);
      $display("test tristate after write done");
      results();
   end
endmodule : tb_top
